// ==== logic/edc_pkg.sv ====
// package for the extended disk command executor: keys, codes, state layout
// assumes 16-bit host registers and a 22-bit word-aligned byte address space
package edc_pkg;

  // ----------------------------------------------------------------------
  // keys, field positions and codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] UNLOCK_KEY = 16'h8001;
  localparam int CSR_ERR = 15;
  localparam int CSR_RDY = 7;
  localparam int CSR_IE = 6;
  localparam logic [2:0] EXT_MARK = 3'h7;
  localparam logic [3:0] FN_SWITCH = 4'h0;
  localparam logic [3:0] FN_FWREAD = 4'h2;
  localparam logic [3:0] FN_FORMAT = 4'h4;
  localparam logic [3:0] FN_BADSECT = 4'h6;
  localparam logic [3:0] FN_PASS_IN = 4'h8;
  localparam logic [3:0] FN_PASS_OUT = 4'ha;
  localparam logic [2:0] STD_GETSTAT = 3'h2;
  localparam int DAR_RST = 3;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] CSR_RESET = 16'h0080;
  localparam logic [15:0] INTERLACE_ONE = 16'h0001;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 16;

  // ----------------------------------------------------------------------
  // register select codes on the host write port
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_CSR = 3'h0;
  localparam logic [2:0] SEL_BAR = 3'h1;
  localparam logic [2:0] SEL_DAR = 3'h2;
  localparam logic [2:0] SEL_MPR = 3'h3;
  localparam logic [2:0] SEL_BAE = 3'h4;
  localparam logic [2:0] SEL_DADDR = 3'h5;
  localparam logic [2:0] SEL_DCOUNT = 3'h6;
  localparam logic [2:0] SEL_CEXT = 3'h7;

  localparam logic [1:0] OP_FORMAT = 2'h1;
  localparam logic [1:0] OP_BADSECT = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DRVOP,
    ST_CMDFETCH,
    ST_DATA,
    ST_STATUS
  } edc_state_e;

  typedef struct packed {
    logic write;
    logic [2:0] sel;
    logic [15:0] data;
  } edc_hostwr_s;

  typedef struct packed {
    edc_state_e st;
    logic [15:0] control_status_reg;
    logic [15:0] bar;
    logic [15:0] disk_address_reg;
    logic [15:0] multipurpose_reg;
    logic [15:0] bae;
    logic [15:0] dataAddr;
    logic [15:0] dataWc;
    logic [15:0] cmdExt;
    logic [15:0] cmdAddr;
    logic [15:0] cmdWc;
    logic [15:0] dataLeft;
    logic [15:0] rxLeft;
    logic dirOut;
    logic [3:0] lock;
    logic [3:0] volChk;
    logic [3:0] fwNext;
    logic fwChain;
    logic memReq;
    logic memWe;
    logic [21:0] memAddr;
    logic [15:0] memWdata;
    logic txValid;
    logic txCmd;
    logic [15:0] txData;
    logic rxHoldV;
    logic [15:0] rxHoldD;
    logic rxReady;
    logic scsiStart;
    logic drvReq;
    logic [1:0] drvOp;
    logic [15:0] drvParam;
    logic stdStrobe;
    logic irq;
  } edc_state_s;

endpackage : edc_pkg

// ==== logic/edc_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset, depth a power of two
module edc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wrPtr] <= inData;
        wrPtr <= wrPtr + AW'(1);
      end
      if (pop)
        rdPtr <= rdPtr + AW'(1);
      if (push && !pop)
        count <= count + (AW+1)'(1);
      else if (pop && !push)
        count <= count - (AW+1)'(1);
    end
  end

endmodule : edc_fifo

// ==== logic/edc_executor.sv ====
// extended command executor: host registers, command decode, drive ops, passthrough
// assumes host writes one register per strobe and memory answers one request at a time
// Functional notes
// - unlock key in bus address enables extended
// - extended: csr bits 13..11 set, code 3..0
// - reset bit plus get-status clears volume check
// - completion sets ready, interrupts when enabled
// - code 0 copies multipurpose into lock switches
// - lock bit zero permits writes, one blocks
// - code 2 reads addressed firmware register
// - back-to-back reads step firmware address
// - code 4 formats, zero interlace means 1:1
// - code 6 writes empty bad-sector file
// - passthrough sends packet, inbound data by dma
// - zero data count means no data transfer
// - success: error clear, status, next address
// - outbound passthrough reads data from memory
// - reserved codes only set ready, interrupt
module edc_executor
  import edc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host register writes
  input wire edc_pkg::edc_hostwr_s hostWr,
  // register view
  output logic [15:0] csrOut,
  output logic [15:0] barOut,
  output logic [15:0] darOut,
  output logic [15:0] mprOut,
  output logic stdCmdStrobe,
  output logic irqPulse,
  // drive control
  input wire logic [3:0] volCheckSet,
  input wire logic [15:0] cfgWord,
  output logic [3:0] writeLock,
  output logic [3:0] writeEnable,
  output logic [3:0] volCheck,
  output logic drvOpReq,
  output logic [1:0] drvOpCode,
  output logic [1:0] drvSel,
  output logic [15:0] drvOpParam,
  input wire logic drvOpDone,
  // memory dma
  output logic memReq,
  output logic memWe,
  output logic [21:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic [15:0] memRdata,
  // scsi stream
  output logic scsiStart,
  output logic scsiDirOut,
  output logic txValid,
  output logic txCmd,
  output logic [15:0] txData,
  input wire logic txReady,
  input wire logic rxValid,
  output logic rxReady,
  input wire logic [15:0] rxData,
  input wire logic scsiDone,
  input wire logic [15:0] scsiStatus
);

  import edc_pkg::*;

  edc_state_s r;
  edc_state_s n;
  logic fifoInValid;
  logic fifoInReady;
  logic [15:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [15:0] fifoOutData;
  logic csrWrite;
  logic extCmd;
  logic [3:0] fn;
  logic [3:0] fwAddr;
  logic [15:0] fwValue;

  // ----------------------------------------------------------------------
  // data buffer
  // ----------------------------------------------------------------------
  edc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.stdStrobe = 1'b0;
    n.irq = 1'b0;
    n.drvReq = 1'b0;
    n.scsiStart = 1'b0;
    fifoInValid = 1'b0;
    fifoInData = memRdata;
    fifoOutReady = 1'b0;
    csrWrite = hostWr.write && hostWr.sel == SEL_CSR && r.st == ST_IDLE;
    extCmd = r.bar == UNLOCK_KEY && hostWr.data[13:11] == EXT_MARK;
    fn = hostWr.data[3:0];
    fwAddr = r.fwChain ? r.fwNext : r.multipurpose_reg[3:0];
    case (fwAddr)
      4'h0: fwValue = {12'h000, r.lock};
      4'h1: fwValue = {12'h000, r.volChk};
      4'h2: fwValue = cfgWord;
      default: fwValue = 16'h0000;
    endcase
    // volume check: set wins over clear
    if (csrWrite && !extCmd && hostWr.data[3:1] == STD_GETSTAT && r.disk_address_reg[DAR_RST])
      n.volChk[hostWr.data[9:8]] = 1'b0;
    n.volChk = n.volChk | volCheckSet;
    if (r.txValid && txReady)
      n.txValid = 1'b0;
    if (memAck)
      n.memReq = 1'b0;
    // host register writes, taken only while idle
    if (hostWr.write && r.st == ST_IDLE)
    begin
      if (hostWr.sel == SEL_BAR)
        n.bar = hostWr.data;
      else if (hostWr.sel == SEL_DAR)
        n.disk_address_reg = hostWr.data;
      else if (hostWr.sel == SEL_MPR)
      begin
        n.multipurpose_reg = hostWr.data;
        n.fwChain = 1'b0;
      end
      else if (hostWr.sel == SEL_BAE)
        n.bae = hostWr.data;
      else if (hostWr.sel == SEL_DADDR)
        n.dataAddr = hostWr.data;
      else if (hostWr.sel == SEL_DCOUNT)
        n.dataWc = hostWr.data;
      else if (hostWr.sel == SEL_CEXT)
        n.cmdExt = hostWr.data;
    end
    if (csrWrite)
    begin
      n.control_status_reg = {1'b0, hostWr.data[14:8], 1'b0, hostWr.data[6:0]};
      if (!extCmd)
      begin
        n.stdStrobe = 1'b1;
        n.fwChain = 1'b0;
      end
      else if (fn == FN_SWITCH)
      begin
        n.lock = r.multipurpose_reg[3:0];
        n.control_status_reg[CSR_RDY] = 1'b1;
        n.irq = hostWr.data[CSR_IE];
        n.fwChain = 1'b0;
      end
      else if (fn == FN_FWREAD)
      begin
        n.multipurpose_reg = fwValue;
        n.fwNext = fwAddr + 4'h1;
        n.fwChain = 1'b1;
        n.control_status_reg[CSR_RDY] = 1'b1;
        n.irq = hostWr.data[CSR_IE];
      end
      else if (fn == FN_FORMAT || fn == FN_BADSECT)
      begin
        n.drvReq = 1'b1;
        n.drvOp = (fn == FN_FORMAT) ? OP_FORMAT : OP_BADSECT;
        if (fn == FN_FORMAT && r.multipurpose_reg == 16'h0000)
          n.drvParam = INTERLACE_ONE;
        else
          n.drvParam = r.multipurpose_reg;
        n.st = ST_DRVOP;
        n.fwChain = 1'b0;
      end
      else if (fn == FN_PASS_IN || fn == FN_PASS_OUT)
      begin
        n.dirOut = (fn == FN_PASS_OUT);
        n.cmdAddr = r.disk_address_reg;
        n.cmdWc = r.multipurpose_reg;
        n.scsiStart = 1'b1;
        n.st = ST_CMDFETCH;
        n.fwChain = 1'b0;
      end
      else
      begin
        n.control_status_reg[CSR_RDY] = 1'b1;
        n.irq = hostWr.data[CSR_IE];
        n.fwChain = 1'b0;
      end
    end
    case (r.st)
      ST_DRVOP:
      begin
        if (drvOpDone)
        begin
          n.control_status_reg[CSR_RDY] = 1'b1;
          n.irq = r.control_status_reg[CSR_IE];
          n.st = ST_IDLE;
        end
      end
      ST_CMDFETCH:
      begin
        if (memAck)
        begin
          n.txValid = 1'b1;
          n.txCmd = 1'b1;
          n.txData = memRdata;
          n.cmdWc = r.cmdWc + COUNT_STEP;
          n.cmdAddr = r.cmdAddr + WORD_STEP;
        end
        else if (!r.memReq && !r.txValid && r.cmdWc != 16'h0000)
        begin
          n.memReq = 1'b1;
          n.memWe = 1'b0;
          n.memAddr = {r.cmdExt[5:0], r.cmdAddr};
        end
        else if (!r.memReq && !r.txValid)
        begin
          n.dataLeft = r.dataWc;
          n.rxLeft = r.dataWc;
          n.st = (r.dataWc == 16'h0000) ? ST_STATUS : ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (r.dirOut)
        begin
          // memory to buffer to scsi
          if (memAck)
          begin
            fifoInValid = 1'b1;
            n.dataLeft = r.dataLeft + COUNT_STEP;
            n.dataAddr = r.dataAddr + WORD_STEP;
          end
          else if (!r.memReq && fifoInReady && r.dataLeft != 16'h0000)
          begin
            n.memReq = 1'b1;
            n.memWe = 1'b0;
            n.memAddr = {r.bae[5:0], r.dataAddr};
          end
          fifoOutReady = !r.txValid || txReady;
          if (fifoOutValid && fifoOutReady)
          begin
            n.txValid = 1'b1;
            n.txCmd = 1'b0;
            n.txData = fifoOutData;
          end
          if (r.dataLeft == 16'h0000 && !r.memReq && !fifoOutValid && !r.txValid)
            n.st = ST_STATUS;
        end
        else
        begin
          // scsi to buffer to memory
          fifoInValid = r.rxHoldV;
          fifoInData = r.rxHoldD;
          if (r.rxHoldV && fifoInReady)
            n.rxHoldV = 1'b0;
          if (r.rxReady && rxValid)
          begin
            n.rxHoldV = 1'b1;
            n.rxHoldD = rxData;
            n.rxLeft = r.rxLeft + COUNT_STEP;
          end
          if (memAck)
          begin
            n.dataLeft = r.dataLeft + COUNT_STEP;
            n.dataAddr = r.dataAddr + WORD_STEP;
          end
          else if (!r.memReq && fifoOutValid)
          begin
            fifoOutReady = 1'b1;
            n.memReq = 1'b1;
            n.memWe = 1'b1;
            n.memAddr = {r.bae[5:0], r.dataAddr};
            n.memWdata = fifoOutData;
          end
          if (r.dataLeft == 16'h0000 && !r.memReq)
            n.st = ST_STATUS;
        end
      end
      ST_STATUS:
      begin
        if (scsiDone)
        begin
          n.disk_address_reg = scsiStatus;
          n.bar = r.dataAddr;
          n.control_status_reg[CSR_ERR] = (scsiStatus != 16'h0000);
          n.control_status_reg[CSR_RDY] = 1'b1;
          n.irq = r.control_status_reg[CSR_IE];
          n.st = ST_IDLE;
        end
      end
      default:
      begin
      end
    endcase
    n.rxReady = n.st == ST_DATA && !n.dirOut && n.rxLeft != 16'h0000 && !n.rxHoldV;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.control_status_reg <= CSR_RESET;
    end
    else
      r <= n;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign csrOut = r.control_status_reg;
  assign barOut = r.bar;
  assign darOut = r.disk_address_reg;
  assign mprOut = r.multipurpose_reg;
  assign stdCmdStrobe = r.stdStrobe;
  assign irqPulse = r.irq;
  assign writeLock = r.lock;
  assign writeEnable = ~r.lock;
  assign volCheck = r.volChk;
  assign drvOpReq = r.drvReq;
  assign drvOpCode = r.drvOp;
  assign drvSel = r.control_status_reg[9:8];
  assign drvOpParam = r.drvParam;
  assign memReq = r.memReq;
  assign memWe = r.memWe;
  assign memAddr = r.memAddr;
  assign memWdata = r.memWdata;
  assign scsiStart = r.scsiStart;
  assign scsiDirOut = r.dirOut;
  assign txValid = r.txValid;
  assign txCmd = r.txCmd;
  assign txData = r.txData;
  assign rxReady = r.rxReady;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_std_decode: assert property (csrWrite && r.bar != UNLOCK_KEY |=> stdCmdStrobe)
    else $error("control word without key not standard");
  a_ext_nostd: assert property (csrWrite && extCmd |=> !stdCmdStrobe)
    else $error("extended command taken as standard");
  a_ready_irq: assert property ($rose(csrOut[CSR_RDY]) |-> irqPulse == csrOut[CSR_IE])
    else $error("completion interrupt mismatch");
  a_lock_load: assert property (csrWrite && extCmd && fn == FN_SWITCH
    |=> writeLock == $past(mprOut[3:0]) && writeEnable == ~writeLock)
    else $error("write lock not loaded");
  a_reserved_nop: assert property (csrWrite && extCmd && fn == FN_PASS_OUT + 4'h2
    |=> csrOut[CSR_RDY] && !memReq && !drvOpReq && !scsiStart)
    else $error("reserved code did work");
  a_fw_step: assert property (csrWrite && extCmd && fn == FN_FWREAD
    |=> r.fwChain && r.fwNext == $past(fwAddr) + 4'h1)
    else $error("firmware address not stepped");
  a_interlace_min: assert property (drvOpReq && drvOpCode == OP_FORMAT |-> drvOpParam != 0)
    else $error("format interlace zero");
  a_zero_skip: assert property (r.st == ST_CMDFETCH && r.cmdWc == 0 && !r.memReq
    && !r.txValid && r.dataWc == 0 |=> r.st == ST_STATUS [*1] ##0 !memReq)
    else $error("zero count still moved data");
  a_status_latch: assert property (r.st == ST_STATUS && scsiDone
    |=> darOut == $past(scsiStatus) && csrOut[CSR_RDY] && barOut == $past(r.dataAddr))
    else $error("termination status not latched");
  a_drvop_done: assert property (r.st == ST_DRVOP && drvOpDone |=> csrOut[CSR_RDY])
    else $error("drive op did not finish");

  c_pass_in: cover property (r.st == ST_DATA && !r.dirOut ##[1:200] r.st == ST_STATUS);
  c_pass_out: cover property (r.st == ST_DATA && r.dirOut && !fifoInReady);
  c_fw_chain: cover property (csrWrite && extCmd && fn == FN_FWREAD ##1 csrWrite && extCmd);
  c_format: cover property (drvOpReq && drvOpCode == OP_FORMAT);

endmodule : edc_executor

// ==== testbench/edc_far_side.sv ====
// far-side model: host memory, scsi target and drive mechanics
// assumes the executor's clock and its sync active-high reset
module edc_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // behaviour set by the bench
  input wire logic slow,
  input wire logic [7:0] txWords,
  input wire logic [7:0] rxWords,
  input wire logic [15:0] endStatus,
  // memory
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [21:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic [15:0] memRdata,
  // scsi stream
  input wire logic scsiStart,
  input wire logic txValid,
  output logic txReady,
  output logic rxValid,
  input wire logic rxReady,
  output logic [15:0] rxData,
  output logic scsiDone,
  output logic [15:0] scsiStatus,
  // drive operations
  input wire logic drvOpReq,
  output logic drvOpDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:63];
  logic [15:0] rdWord = 16'h0000;
  logic [4:0] memWait = 5'd0;
  logic [4:0] opWait = 5'd0;
  logic [3:0] quiet = 4'd0;
  logic [7:0] txCnt = 8'd0;
  logic [7:0] rxCnt = 8'd0;
  logic active = 1'b0;
  logic tgl = 1'b0;

  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = 16'ha000 + 16'(i);
    memAck = 1'b0;
    rxValid = 1'b0;
    scsiDone = 1'b0;
    drvOpDone = 1'b0;
  end

  // ----------------------------------------------------------------------
  // memory, prompt or slow; released data shows the inverse
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    memAck <= 1'b0;
    quiet <= memReq ? 4'd0 : (quiet == 4'hf ? quiet : quiet + 4'd1);
    if (memReq && !memAck)
    begin
      if (memWait == (slow ? 5'd3 : 5'd0))
      begin
        memAck <= 1'b1;
        memWait <= 5'd0;
        rdWord <= mem[memAddr[6:1]];
        if (memWe)
          mem[memAddr[6:1]] <= memWdata;
      end
      else
        memWait <= memWait + 5'd1;
    end
  end
  assign memRdata = memAck ? rdWord : ~rdWord;

  // ----------------------------------------------------------------------
  // scsi target: takes packet and data, returns data, then status
  // ----------------------------------------------------------------------
  assign txReady = active && (!slow || tgl);
  assign rxData = rxValid ? (16'hc000 + {8'h00, rxCnt}) : ~(16'hc000 + {8'h00, rxCnt});
  assign scsiStatus = scsiDone ? endStatus : ~endStatus;
  always @(posedge clk)
  begin
    scsiDone <= 1'b0;
    tgl <= ~tgl;
    if (rst)
    begin
      active <= 1'b0;
      rxValid <= 1'b0;
    end
    else if (scsiStart)
    begin
      active <= 1'b1;
      txCnt <= 8'd0;
      rxCnt <= 8'd0;
    end
    else if (active)
    begin
      if (txValid && txReady)
        txCnt <= txCnt + 8'd1;
      if (rxValid && rxReady)
      begin
        rxValid <= 1'b0;
        rxCnt <= rxCnt + 8'd1;
      end
      else if (!rxValid && txCnt == txWords && rxCnt < rxWords)
        rxValid <= 1'b1;
      if (txCnt == txWords && rxCnt == rxWords && !rxValid && quiet > 4'd8)
      begin
        scsiDone <= 1'b1;
        active <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // drive always selected and on line; ops finish after a delay
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    drvOpDone <= 1'b0;
    if (rst)
      opWait <= 5'd0;
    else if (drvOpReq)
      opWait <= slow ? 5'd20 : 5'd4;
    else if (opWait != 5'd0)
    begin
      opWait <= opWait - 5'd1;
      drvOpDone <= (opWait == 5'd1);
    end
  end
endmodule : edc_far_side

// ==== testbench/tb_edc_executor.sv ====
// self-checking bench for the extended command executor
// assumes edc_pkg and the far-side model are compiled first
module tb_edc_executor;
  timeunit 1ns;
  timeprecision 1ps;
  import edc_pkg::*;
  logic clk = 1'b0;
  logic rst, slow, memReq, memWe, memAck, scsiStart, scsiDirOut, txValid, txCmd, txReady;
  logic rxValid, rxReady, scsiDone, stdCmdStrobe, irqPulse, drvOpReq, drvOpDone;
  logic [1:0] drvOpCode, drvSel;
  logic [3:0] volCheckSet, writeLock, writeEnable, volCheck;
  logic [7:0] txWords, rxWords;
  logic [15:0] cfgWord, endStatus, csrOut, barOut, darOut, mprOut, drvOpParam;
  logic [15:0] memWdata, memRdata, txData, rxData, scsiStatus;
  logic [21:0] memAddr;
  edc_hostwr_s hostWr;
  int errCount, samplesChecked, irqCnt, stdCnt, opCnt, cycles;
  logic [16:0] txLog [$];

  edc_executor uut (.clk(clk), .rst(rst), .hostWr(hostWr), .csrOut(csrOut), .barOut(barOut),
    .darOut(darOut), .mprOut(mprOut), .stdCmdStrobe(stdCmdStrobe), .irqPulse(irqPulse),
    .volCheckSet(volCheckSet), .cfgWord(cfgWord), .writeLock(writeLock),
    .writeEnable(writeEnable), .volCheck(volCheck), .drvOpReq(drvOpReq), .drvOpCode(drvOpCode),
    .drvSel(drvSel), .drvOpParam(drvOpParam), .drvOpDone(drvOpDone), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .scsiStart(scsiStart), .scsiDirOut(scsiDirOut), .txValid(txValid),
    .txCmd(txCmd), .txData(txData), .txReady(txReady), .rxValid(rxValid), .rxReady(rxReady),
    .rxData(rxData), .scsiDone(scsiDone), .scsiStatus(scsiStatus));

  edc_far_side far (.clk(clk), .rst(rst), .slow(slow), .txWords(txWords), .rxWords(rxWords),
    .endStatus(endStatus), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .scsiStart(scsiStart),
    .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .rxReady(rxReady),
    .rxData(rxData), .scsiDone(scsiDone), .scsiStatus(scsiStatus), .drvOpReq(drvOpReq),
    .drvOpDone(drvOpDone));

  always #2 clk = ~clk;

  // ----------------------------------------------------------------------
  // monitors and watchdog
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (irqPulse === 1'b1) irqCnt++;
    if (stdCmdStrobe === 1'b1) stdCnt++;
    if (drvOpReq === 1'b1) opCnt++;
    if (txValid === 1'b1 && txReady === 1'b1) txLog.push_back({txCmd, txData});
    if (cycles == 20000)
    begin
      errCount++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (errCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic hw(input logic [2:0] sel, input logic [15:0] data);
    @(posedge clk);
    hostWr <= '{1'b1, sel, data};
    @(posedge clk);
    hostWr.write <= 1'b0;
  endtask : hw

  task automatic ext(input logic [3:0] code, input logic ie, input logic [1:0] sel);
    int n;
    hw(SEL_BAR, UNLOCK_KEY);
    hw(SEL_CSR, 16'h3800 | {6'h00, sel, 1'b0, ie, 2'h0, code});
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (csrOut[CSR_RDY] !== 1'b1 && n < 2000);
    check("ready", 32'(n < 2000), 32'h1);
    @(posedge clk);
    #1;
  endtask : ext

  task automatic tSwitch();
    int i0;
    check("reset csr", csrOut, CSR_RESET);
    check("reset wen", writeEnable, 4'hf);
    hw(SEL_MPR, 16'h0003);
    i0 = irqCnt;
    ext(FN_SWITCH, 1'b0, 2'h0);
    check("lock a", writeLock, 4'h3);
    check("irq off", irqCnt - i0, 0);
    hw(SEL_MPR, 16'hfff5);
    ext(FN_SWITCH, 1'b1, 2'h0);
    check("lock b", writeLock, 4'h5);
    check("wen", writeEnable, 4'ha);
    check("irq on", irqCnt - i0, 1);
  endtask : tSwitch

  task automatic tReserved();
    logic [3:0] codes [4] = '{4'hc, 4'he, 4'h1, 4'hf};
    int i0;
    hw(SEL_MPR, 16'h000f);
    foreach (codes[k])
    begin
      i0 = irqCnt;
      ext(codes[k], 1'b1, 2'h0);
      check("rsv lock", writeLock, 4'h5);
      check("rsv mpr", mprOut, 16'h000f);
      check("rsv irq", irqCnt - i0, 1);
    end
  endtask : tReserved

  task automatic tFwRead();
    @(posedge clk);
    volCheckSet <= 4'h4;
    @(posedge clk);
    volCheckSet <= 4'h0;
    hw(SEL_MPR, 16'h0000);
    ext(FN_FWREAD, 1'b0, 2'h0);
    check("fw0", mprOut, 16'h0005);
    ext(FN_FWREAD, 1'b0, 2'h0);
    check("fw1", mprOut, 16'h0004);
    ext(FN_FWREAD, 1'b0, 2'h0);
    check("fw2", mprOut, cfgWord);
  endtask : tFwRead

  task automatic tDrvOp(input logic [3:0] code, input logic [15:0] multipurpose_reg, input logic [15:0] par,
                        input logic [1:0] op, input logic [1:0] sel, input logic s);
    int i0;
    slow <= s;
    hw(SEL_MPR, multipurpose_reg);
    i0 = opCnt;
    ext(code, 1'b1, sel);
    check("op count", opCnt - i0, 1);
    check("op code", drvOpCode, op);
    check("op param", drvOpParam, par);
    check("op sel", drvSel, sel);
  endtask : tDrvOp

  task automatic tPass(input logic outb, input logic [7:0] nd, input logic [15:0] st,
                       input logic s);
    int i0;
    logic [15:0] base;
    base = outb ? 16'h0020 : 16'h0040;
    slow <= s;
    txWords <= outb ? 8'd2 + nd : 8'd2;
    rxWords <= outb ? 8'd0 : nd;
    endStatus <= st;
    hw(SEL_DAR, 16'h0010);
    hw(SEL_MPR, 16'hfffe);
    hw(SEL_BAE, 16'h0000);
    hw(SEL_DADDR, base);
    hw(SEL_DCOUNT, 16'h0000 - {8'h00, nd});
    hw(SEL_CEXT, 16'h0000);
    txLog.delete();
    i0 = irqCnt;
    ext(outb ? FN_PASS_OUT : FN_PASS_IN, 1'b1, 2'h1);
    check("tx count", txLog.size(), txWords);
    check("cmd0", txLog[0], 17'h1a008);
    check("cmd1", txLog[1], 17'h1a009);
    for (int k = 0; k < nd; k++)
      if (outb)
        check("tx data", txLog[2 + k], {1'b0, 16'ha010 + 16'(k)});
      else
        check("mem data", far.mem[32 + k], 16'hc000 + 16'(k));
    if (!outb && nd == 0)
      check("no data", far.mem[32], 16'ha020);
    check("status", darOut, st);
    check("next addr", barOut, base + {7'h00, nd, 1'b0});
    check("err", csrOut[CSR_ERR], st != 16'h0000);
    check("dir", scsiDirOut, outb);
    check("pass irq", irqCnt - i0, 1);
  endtask : tPass

  task automatic tStandard();
    int s0;
    int o0;
    s0 = stdCnt;
    o0 = opCnt;
    hw(SEL_BAR, 16'h0000);
    hw(SEL_DAR, 16'h000b);
    hw(SEL_CSR, 16'h3a04);
    repeat (3) @(posedge clk);
    #1;
    check("std strobe", stdCnt - s0, 1);
    check("std no op", opCnt - o0, 0);
    check("vol clear", volCheck, 4'h0);
  endtask : tStandard

  initial
  begin
    rst = 1'b1;
    hostWr = '0;
    volCheckSet = 4'h0;
    cfgWord = 16'h5a3c;
    slow = 1'b0;
    txWords = 8'd0;
    rxWords = 8'd0;
    endStatus = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    tSwitch();
    tReserved();
    tFwRead();
    tDrvOp(FN_FORMAT, 16'h0000, INTERLACE_ONE, OP_FORMAT, 2'h1, 1'b0);
    tDrvOp(FN_FORMAT, 16'h0003, 16'h0003, OP_FORMAT, 2'h2, 1'b1);
    tDrvOp(FN_BADSECT, 16'h1234, 16'h1234, OP_BADSECT, 2'h3, 1'b0);
    tPass(1'b0, 8'd0, 16'h0002, 1'b0);
    tPass(1'b0, 8'd10, 16'h0000, 1'b1);
    tPass(1'b1, 8'd2, 16'h0000, 1'b0);
    tStandard();
    summarize();
  end
endmodule : tb_edc_executor
